// file: rtl/tcap_pkg.sv
/*
 * Shared constants for the test-port configuration array programmer:
 * instruction codes, register widths, reset values and link timing.
 * Assumes both ends and the bench are compiled after this package.
 */
package tcap_pkg;
    // Instruction register
    localparam int         IR_W          = 8;
    localparam logic [7:0] IR_CAPTURE    = 8'h01;
    localparam logic [7:0] OP_PROG_EN    = 8'h15;
    localparam logic [7:0] OP_PROG_DIS   = 8'h1e;
    localparam logic [7:0] OP_DONE_ERASE = 8'h24;
    localparam logic [7:0] OP_CFG_VERIFY = 8'h28;
    localparam logic [7:0] OP_CFG_ERASE  = 8'h29;
    localparam logic [7:0] OP_CFG_ADDR   = 8'h2b;
    localparam logic [7:0] OP_CFG_DATA   = 8'h2d;
    localparam logic [7:0] OP_CFG_PROG   = 8'h2e;
    localparam logic [7:0] OP_DONE_PROG  = 8'h2f;
    localparam logic [7:0] OP_BYPASS     = 8'hff;

    // Data registers and array
    localparam int          ADDR_W     = 4;
    localparam int          DATA_W     = 56;
    localparam int          CFG_COLS   = 16;
    localparam logic [55:0] ERASED_COL = 56'h0;
    localparam logic        DONE_RESET = 1'b0;
    localparam logic        PMODE_RESET = 1'b0;

    // Action fires on this rising edge spent in Run-Test-Idle
    localparam logic [1:0] RTI_FIRE_EDGE = 2'h2;

    // Host sequencing, counted in test-clock steps
    localparam int TLR_STEPS   = 5;
    localparam int IR_HDR_STEPS = 4;
    localparam int DR_HDR_STEPS = 3;
    localparam int RTI_STEPS   = 3;

    // Link timing
    localparam int TCK_PERIOD_NS = 160;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TCK_HALF_CLKS = (TCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
endpackage : tcap_pkg

// file: rtl/tcap_link_if.sv
/*
 * Test access port wires between the programming host and the device.
 * Assumes the bench joins one host and one device; TDO idles high when undriven.
 */
`timescale 1ns/1ps
interface tcap_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic tdo_line;

    // Pull-up on the serial output when the device releases it
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    modport dev (
        input  tck,
        input  tms,
        input  tdi,
        output tdo,
        output tdo_oe
    );

    modport host (
        output tck,
        output tms,
        output tdi,
        input  tdo_line
    );
endinterface : tcap_link_if

// file: rtl/tcap_dev.sv
/*
 * Device end: test access port state machine, instruction and data
 * registers, programming mode, done flag and the configuration array.
 * Assumes tck, tms and tdi arrive asynchronously and are far slower than clk_sys_i.
 */
`timescale 1ns/1ps
module tcap_dev #(
    parameter int COLS = tcap_pkg::CFG_COLS
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         nrst_i,
    tcap_link_if.dev                          link,
    input  wire logic [tcap_pkg::ADDR_W-1:0]  rd_addr_i,
    output logic      [tcap_pkg::DATA_W-1:0]  rd_data_o,
    output logic                              done_o,
    output logic                              prog_mode_o
);
    localparam int AW = tcap_pkg::ADDR_W;
    localparam int DW = tcap_pkg::DATA_W;

    typedef enum logic [15:0] {
        TLR    = 16'h0001,
        RTI    = 16'h0002,
        SEL_DR = 16'h0004,
        CAP_DR = 16'h0008,
        SH_DR  = 16'h0010,
        EX1_DR = 16'h0020,
        PA_DR  = 16'h0040,
        EX2_DR = 16'h0080,
        UP_DR  = 16'h0100,
        SEL_IR = 16'h0200,
        CAP_IR = 16'h0400,
        SH_IR  = 16'h0800,
        EX1_IR = 16'h1000,
        PA_IR  = 16'h2000,
        EX2_IR = 16'h4000,
        UP_IR  = 16'h8000
    } tcap_tap_t;

    tcap_tap_t            tap;
    tcap_tap_t            next_tap;
    logic [2:0]           tck_sync;
    logic [1:0]           tms_sync;
    logic [1:0]           tdi_sync;
    logic                 tck_rise;
    logic                 tck_fall;
    logic                 tms_s;
    logic                 tdi_s;
    logic [7:0]           ir;
    logic [7:0]           ir_sh;
    logic [DW-1:0]        dr_sh;
    logic [AW-1:0]        col_addr;
    logic [DW-1:0]        data_reg;
    logic [1:0]           rti_cnt;
    logic                 rti_fire;
    logic                 erase_fire;
    logic                 prog_fire;
    logic [DW-1:0]        cfg_mem [COLS];
    logic                 sel_addr;
    logic                 sel_data;

    // Two flops per data pin, three for the clock; edge detect only looks at the second and third stage
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tck_sync <= 3'h0;
            tms_sync <= 2'h0;
            tdi_sync <= 2'h0;
        end else begin
            tck_sync <= {tck_sync[1:0], link.tck};
            tms_sync <= {tms_sync[0], link.tms};
            tdi_sync <= {tdi_sync[0], link.tdi};
        end
    end

    assign tck_rise = tck_sync[1] & ~tck_sync[2];
    assign tck_fall = ~tck_sync[1] & tck_sync[2];
    assign tms_s    = tms_sync[1];
    assign tdi_s    = tdi_sync[1];

    // Which data register sits between serial input and output
    assign sel_addr = (ir == tcap_pkg::OP_CFG_ADDR);
    assign sel_data = (ir == tcap_pkg::OP_CFG_DATA);

    // Standard test access port transitions
    always_comb begin
        next_tap = tap;
        unique case (tap)
            TLR:    next_tap = tms_s ? TLR    : RTI;
            RTI:    next_tap = tms_s ? SEL_DR : RTI;
            SEL_DR: next_tap = tms_s ? SEL_IR : CAP_DR;
            CAP_DR: next_tap = tms_s ? EX1_DR : SH_DR;
            SH_DR:  next_tap = tms_s ? EX1_DR : SH_DR;
            EX1_DR: next_tap = tms_s ? UP_DR  : PA_DR;
            PA_DR:  next_tap = tms_s ? EX2_DR : PA_DR;
            EX2_DR: next_tap = tms_s ? UP_DR  : SH_DR;
            UP_DR:  next_tap = tms_s ? SEL_DR : RTI;
            SEL_IR: next_tap = tms_s ? TLR    : CAP_IR;
            CAP_IR: next_tap = tms_s ? EX1_IR : SH_IR;
            SH_IR:  next_tap = tms_s ? EX1_IR : SH_IR;
            EX1_IR: next_tap = tms_s ? UP_IR  : PA_IR;
            PA_IR:  next_tap = tms_s ? EX2_IR : PA_IR;
            EX2_IR: next_tap = tms_s ? UP_IR  : SH_IR;
            UP_IR:  next_tap = tms_s ? SEL_DR : RTI;
            default: next_tap = TLR; // Illegal one-hot code recovers to reset
        endcase
    end

    // State advances only on a test-clock rising edge
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tap <= TLR;
        end else if (tck_rise) begin
            tap <= next_tap;
        end
    end

    // Instruction register: capture, shift, update; reset leaves bypass
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ir_sh <= tcap_pkg::IR_CAPTURE;
            ir    <= tcap_pkg::OP_BYPASS;
        end else if (tck_rise) begin
            unique case (tap)
                TLR:     ir    <= tcap_pkg::OP_BYPASS;
                CAP_IR:  ir_sh <= tcap_pkg::IR_CAPTURE;
                SH_IR:   ir_sh <= {tdi_s, ir_sh[7:1]};
                UP_IR:   ir    <= ir_sh;
                default: ir    <= ir;
            endcase
        end
    end

    // Data shift path; length follows the instruction, bypass is one bit
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            dr_sh <= '0;
        end else if (tck_rise && tap == CAP_DR) begin
            if (sel_data) begin
                dr_sh <= data_reg;
            end else if (sel_addr) begin
                dr_sh <= {{(DW-AW){1'b0}}, col_addr};
            end else begin
                dr_sh <= '0;
            end
        end else if (tck_rise && tap == SH_DR) begin
            if (sel_data) begin
                dr_sh <= {tdi_s, dr_sh[DW-1:1]};
            end else if (sel_addr) begin
                dr_sh <= {{(DW-AW){1'b0}}, tdi_s, dr_sh[AW-1:1]};
            end else begin
                dr_sh <= {{(DW-1){1'b0}}, tdi_s};
            end
        end
    end

    // Column address register, used by every later program or verify
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            col_addr <= '0;
        end else if (tck_rise && tap == UP_DR && sel_addr) begin
            col_addr <= dr_sh[AW-1:0];
        end
    end

    // Count rising edges spent in idle; saturate so one stay fires once
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rti_cnt <= 2'h0;
        end else if (tck_rise) begin
            if (tap != RTI) begin
                rti_cnt <= 2'h0;
            end else if (rti_cnt != tcap_pkg::RTI_FIRE_EDGE) begin
                rti_cnt <= rti_cnt + 2'h1;
            end
        end
    end

    // Second idle edge: the counter has seen exactly one edge before it
    assign rti_fire   = tck_rise && tap == RTI && rti_cnt == (tcap_pkg::RTI_FIRE_EDGE - 2'h1);
    assign erase_fire = rti_fire && prog_mode_o && ir == tcap_pkg::OP_CFG_ERASE;
    assign prog_fire  = rti_fire && prog_mode_o && ir == tcap_pkg::OP_CFG_PROG;

    // Configuration data register: loaded by a data scan or by verify
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            data_reg <= '0;
        end else if (tck_rise && tap == UP_DR && sel_data) begin
            data_reg <= dr_sh;
        end else if (rti_fire && ir == tcap_pkg::OP_CFG_VERIFY) begin
            data_reg <= cfg_mem[col_addr];
        end
    end

    // Programming mode: enable on update, cancel on disable or reset state
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            prog_mode_o <= tcap_pkg::PMODE_RESET;
        end else if (tck_rise && (tap == TLR || next_tap == TLR)) begin
            prog_mode_o <= 1'b0; // Cleared on the edge that enters reset state
        end else if (tck_rise && tap == UP_IR && ir_sh == tcap_pkg::OP_PROG_EN) begin
            prog_mode_o <= 1'b1;
        end else if (tck_rise && tap == UP_IR && ir_sh == tcap_pkg::OP_PROG_DIS) begin
            prog_mode_o <= 1'b0;
        end
    end

    // Done flag; mode gates it like every other erase or program
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            done_o <= tcap_pkg::DONE_RESET;
        end else if (rti_fire && prog_mode_o && ir == tcap_pkg::OP_DONE_ERASE) begin
            done_o <= 1'b0;
        end else if (rti_fire && prog_mode_o && ir == tcap_pkg::OP_DONE_PROG) begin
            done_o <= 1'b1;
        end
    end

    // One writer per column; program overwrites the column, so no erase is needed first
    for (genvar g = 0; g < COLS; g++) begin : g_col
        always_ff @(posedge clk_sys_i) begin
            if (!nrst_i) begin
                cfg_mem[g] <= tcap_pkg::ERASED_COL;
            end else if (erase_fire) begin
                cfg_mem[g] <= tcap_pkg::ERASED_COL;
            end else if (prog_fire && col_addr == AW'(g)) begin
                cfg_mem[g] <= data_reg;
            end
        end
    end

    // User-side read port, one cycle latency
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= cfg_mem[rd_addr_i];
        end
    end

    // Serial output changes on the falling edge, driven only while shifting
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            link.tdo    <= 1'b0;
            link.tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            link.tdo_oe <= (tap == SH_IR) || (tap == SH_DR);
            link.tdo    <= (tap == SH_IR) ? ir_sh[0] : dr_sh[0];
        end
    end
endmodule : tcap_dev

// file: rtl/tcap_host.sv
/*
 * Host end: makes the test clock by division, resets the port, then runs
 * one command at a time: instruction scan, optional data scan, idle edges.
 * Assumes the user keeps cmd inputs stable while cmd_valid_i and not ready.
 */
`timescale 1ns/1ps
module tcap_host #(
    parameter int HALF_CLKS = tcap_pkg::TCK_HALF_CLKS,
    parameter int RTI_TCKS  = tcap_pkg::RTI_STEPS
) (
    input  wire logic                        clk_sys_i,
    input  wire logic                        nrst_i,
    tcap_link_if.host                        link,
    input  wire logic                        cmd_valid_i,
    output logic                             cmd_ready_o,
    input  wire logic [7:0]                  cmd_instr_i,
    input  wire logic [5:0]                  cmd_len_i,
    input  wire logic [tcap_pkg::DATA_W-1:0] cmd_data_i,
    output logic                             rsp_valid_o,
    output logic      [tcap_pkg::DATA_W-1:0] rsp_data_o
);
    localparam int DW = tcap_pkg::DATA_W;

    typedef enum logic [8:0] {
        H_TLR   = 9'h001,
        H_IDLE  = 9'h002,
        H_IRHDR = 9'h004,
        H_IRSH  = 9'h008,
        H_IRUP  = 9'h010,
        H_DRHDR = 9'h020,
        H_DRSH  = 9'h040,
        H_DRUP  = 9'h080,
        H_RTI   = 9'h100
    } tcap_hst_t;

    tcap_hst_t      ph;
    logic [5:0]     div;
    logic           tick;
    logic [5:0]     step;
    logic [7:0]     instr;
    logic [5:0]     len;
    logic [DW-1:0]  tx;
    logic [DW-1:0]  rx;
    logic           samp;
    logic [1:0]     tdo_sync;

    // Half-period divider; the host owns the test clock
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || tick) begin
            div <= 6'h0;
        end else begin
            div <= div + 6'h1;
        end
    end

    assign tick = (div == 6'(HALF_CLKS - 1));

    // Serial return from the device, two flops before use
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tdo_sync <= 2'h3;
        end else begin
            tdo_sync <= {tdo_sync[0], link.tdo_line};
        end
    end

    // Clock toggles every tick; rising samples, falling sets up next bit
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            link.tck <= 1'b0;
        end else if (tick) begin
            link.tck <= ~link.tck;
        end
    end

    // Capture returned data on rising edges during a data shift
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rx <= '0;
        end else if (tick && !link.tck && samp) begin
            rx <= {tdo_sync[1], rx[DW-1:1]};
        end
    end

    // Sequencer steps on the falling edge; tms and tdi then hold a half period
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ph          <= H_TLR;
            step        <= 6'h0;
            link.tms    <= 1'b1;
            link.tdi    <= 1'b0;
            samp        <= 1'b0;
            instr       <= tcap_pkg::OP_BYPASS;
            len         <= 6'h0;
            tx          <= '0;
            cmd_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= '0;
        end else begin
            rsp_valid_o <= 1'b0;
            if (tick && link.tck) begin
                step <= step + 6'h1;
                samp <= 1'b0;
                unique case (ph)
                    H_TLR: begin
                        // Five ones reach Test-Logic-Reset from anywhere, then one zero to idle
                        link.tms <= (step < 6'(tcap_pkg::TLR_STEPS));
                        if (step == 6'(tcap_pkg::TLR_STEPS)) begin
                            ph          <= H_IDLE;
                            cmd_ready_o <= 1'b1;
                        end
                    end
                    H_IDLE: begin
                        link.tms <= 1'b0;
                        step     <= 6'h0;
                        if (cmd_valid_i) begin
                            instr       <= cmd_instr_i;
                            len         <= (cmd_len_i > 6'(DW)) ? 6'(DW) : cmd_len_i;
                            tx          <= cmd_data_i;
                            cmd_ready_o <= 1'b0;
                            ph          <= H_IRHDR;
                        end
                    end
                    H_IRHDR: begin
                        // Idle, select-DR, select-IR, capture-IR, shift-IR
                        link.tms <= (step < 6'h2);
                        if (step == 6'(tcap_pkg::IR_HDR_STEPS - 1)) begin
                            ph   <= H_IRSH;
                            step <= 6'h0;
                        end
                    end
                    H_IRSH: begin
                        link.tdi <= instr[step[2:0]];
                        link.tms <= (step == 6'(tcap_pkg::IR_W - 1));
                        if (step == 6'(tcap_pkg::IR_W - 1)) begin
                            ph <= H_IRUP;
                        end
                    end
                    H_IRUP: begin
                        link.tms <= 1'b1;
                        step     <= 6'h0;
                        ph       <= (len == 6'h0) ? H_RTI : H_DRHDR;
                    end
                    H_DRHDR: begin
                        // Update, select-DR, capture-DR, shift-DR
                        link.tms <= (step == 6'h0);
                        if (step == 6'(tcap_pkg::DR_HDR_STEPS - 1)) begin
                            ph   <= H_DRSH;
                            step <= 6'h0;
                        end
                    end
                    H_DRSH: begin
                        link.tdi <= tx[0];
                        tx       <= {1'b0, tx[DW-1:1]};
                        samp     <= 1'b1;
                        link.tms <= (step == len - 6'h1);
                        if (step == len - 6'h1) begin
                            ph <= H_DRUP;
                        end
                    end
                    H_DRUP: begin
                        link.tms <= 1'b1;
                        step     <= 6'h0;
                        ph       <= H_RTI;
                    end
                    H_RTI: begin
                        // Enough idle edges for the device to act on the second one
                        link.tms <= 1'b0;
                        if (step == 6'(RTI_TCKS)) begin
                            ph          <= H_IDLE;
                            cmd_ready_o <= 1'b1;
                            rsp_valid_o <= 1'b1;
                            rsp_data_o  <= rx >> (7'(DW) - {1'b0, len});
                        end
                    end
                    default: ph <= H_TLR;
                endcase
            end
        end
    end
endmodule : tcap_host

// file: verif/tcap_link_checker.sv
/*
 * Checker for the test-port link between host and device ends.
 * Assumes clk_sys_i and the host reset; link signals are given as plain inputs.
 */
`timescale 1ns/1ps
module tcap_link_checker (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic [2:0] ones_cnt;
    logic       seen_low;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Rising test-clock edges with mode high, saturating so it cannot wrap
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ones_cnt <= 3'h0;
        end else if ($rose(tck) && tms && ones_cnt != 3'h7) begin
            ones_cnt <= ones_cnt + 3'h1;
        end
    end

    // First rising edge seen with mode low after reset
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            seen_low <= 1'b0;
        end else if ($rose(tck) && !tms) begin
            seen_low <= 1'b1;
        end
    end

    property p_tck_half;
        $changed(tck) |=> $stable(tck)[*8];
    endproperty
    a_tck_half: assert property (p_tck_half)
        else $error("test clock half period too short");

    property p_tms_edge;
        $changed(tms) |-> !tck;
    endproperty
    a_tms_edge: assert property (p_tms_edge)
        else $error("mode select moved while test clock high");

    property p_tdi_edge;
        $changed(tdi) |-> !tck;
    endproperty
    a_tdi_edge: assert property (p_tdi_edge)
        else $error("serial input moved while test clock high");

    property p_tdo_edge;
        $changed(tdo) |-> !tck;
    endproperty
    a_tdo_edge: assert property (p_tdo_edge)
        else $error("serial output moved while test clock high");

    property p_oe_edge;
        $changed(tdo_oe) |-> !tck;
    endproperty
    a_oe_edge: assert property (p_oe_edge)
        else $error("output enable moved while test clock high");

    property p_oe_lag;
        $fell(tck) |-> $stable(tdo_oe)[*2];
    endproperty
    a_oe_lag: assert property (p_oe_lag)
        else $error("output enable moved before fall was synchronised");

    property p_tlr_entry;
        $rose(tck) && !tms && !seen_low |-> ones_cnt >= 3'h5;
    endproperty
    a_tlr_entry: assert property (p_tlr_entry)
        else $error("port left reset state too early");

    property p_oe_quiet;
        !seen_low |-> !tdo_oe;
    endproperty
    a_oe_quiet: assert property (p_oe_quiet)
        else $error("device drove serial output before leaving reset state");
endmodule : tcap_link_checker

// file: verif/testbench.sv
/*
 * Bench joining host and device ends; commands go in through the host port.
 * Assumes the package and interface are compiled first; host reset is separate to force Test-Logic-Reset.
 */
`timescale 1ns/1ps
module testbench;
    localparam logic [55:0] D1 = 56'hc3a5_0f1e_2d3c_4b;
    localparam logic [55:0] D2 = 56'h8001_2345_6789_ab;
    logic        clk = 1'b0;
    logic        nrst_dev;
    logic        nrst_host;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [7:0]  cmd_instr;
    logic [5:0]  cmd_len;
    logic [55:0] cmd_data;
    logic        rsp_valid;
    logic [55:0] rsp_data;
    logic [3:0]  rd_addr;
    logic [55:0] rd_data;
    logic        done;
    logic        prog_mode;
    int          n_fail = 0;
    int          n_tests = 0;

    tcap_link_if link();
    tcap_dev u_tcap_dev (.clk_sys_i(clk), .nrst_i(nrst_dev), .link(link), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .done_o(done), .prog_mode_o(prog_mode));
    tcap_host u_tcap_host (.clk_sys_i(clk), .nrst_i(nrst_host), .link(link), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_instr_i(cmd_instr), .cmd_len_i(cmd_len), .cmd_data_i(cmd_data),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
    tcap_link_checker u_tcap_link_checker (.clk_sys_i(clk), .nrst_i(nrst_host), .tck(link.tck),
        .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));

    // 250 MHz system clock
    always #2 clk = ~clk;

    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [55:0] exp, input logic [55:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check

    // Bounded wait at falling edges; a hang ends the run
    task automatic wait_sig(ref logic s, input logic v);
        for (int k = 0; k < 8000 && s !== v; k++) @(negedge clk);
        if (s !== v) begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_sig

    // One whole command: offer, see it taken, collect the answer
    task automatic run(input logic [7:0] ins, input logic [5:0] len, input logic [55:0] din);
        wait_sig(cmd_ready, 1'b1);
        cmd_instr = ins;
        cmd_len = len;
        cmd_data = din;
        cmd_valid = 1'b1;
        wait_sig(cmd_ready, 1'b0);
        cmd_valid = 1'b0;
        wait_sig(rsp_valid, 1'b1);
    endtask : run

    task automatic check_col(input logic [3:0] a, input logic [55:0] exp);
        rd_addr = a;
        repeat (2) @(negedge clk);
        check("column", exp, rd_data);
    endtask : check_col

    // Main sequence
    initial begin
        nrst_dev = 1'b0;
        nrst_host = 1'b0;
        cmd_valid = 1'b0;
        cmd_instr = 8'h00;
        cmd_len = 6'h00;
        cmd_data = 56'h0;
        rd_addr = 4'h0;
        repeat (6) @(negedge clk);
        nrst_dev = 1'b1;
        nrst_host = 1'b1;
        check("mode", 56'h0, {55'h0, prog_mode});
        // Program and done set refused outside programming mode
        run(tcap_pkg::OP_CFG_ADDR, 6'h04, 56'h3);
        run(tcap_pkg::OP_CFG_DATA, 6'h38, D1);
        run(tcap_pkg::OP_CFG_PROG, 6'h00, 56'h0);
        check_col(4'h3, 56'h0);
        run(tcap_pkg::OP_DONE_PROG, 6'h00, 56'h0);
        check("done", 56'h0, {55'h0, done});
        run(tcap_pkg::OP_PROG_EN, 6'h00, 56'h0);
        check("mode", 56'h1, {55'h0, prog_mode});
        // Erase first, then write the held data to the held column
        run(tcap_pkg::OP_CFG_ERASE, 6'h00, 56'h0);
        run(tcap_pkg::OP_CFG_PROG, 6'h00, 56'h0);
        check_col(4'h3, D1);
        run(tcap_pkg::OP_CFG_ADDR, 6'h04, 56'h5);
        check("addr capture", 56'h3, {52'h0, rsp_data[3:0]});
        run(tcap_pkg::OP_CFG_DATA, 6'h38, D2);
        check("data capture", D1, rsp_data);
        run(tcap_pkg::OP_CFG_PROG, 6'h00, 56'h0);
        check_col(4'h5, D2);
        check_col(4'h3, D1);
        // Verify loads the addressed column for readback
        run(tcap_pkg::OP_CFG_ADDR, 6'h04, 56'h3);
        run(tcap_pkg::OP_CFG_VERIFY, 6'h00, 56'h0);
        run(tcap_pkg::OP_CFG_DATA, 6'h38, 56'h0);
        check("verify", D1, rsp_data);
        // Done flag erase, set, erase
        run(tcap_pkg::OP_DONE_ERASE, 6'h00, 56'h0);
        run(tcap_pkg::OP_DONE_PROG, 6'h00, 56'h0);
        check("done", 56'h1, {55'h0, done});
        run(tcap_pkg::OP_DONE_ERASE, 6'h00, 56'h0);
        check("done", 56'h0, {55'h0, done});
        run(tcap_pkg::OP_CFG_ERASE, 6'h00, 56'h0);
        for (int i = 0; i < 16; i++) check_col(i[3:0], 56'h0);
        // Disable, then Test-Logic-Reset, both drop programming mode
        run(tcap_pkg::OP_PROG_DIS, 6'h00, 56'h0);
        check("mode", 56'h0, {55'h0, prog_mode});
        run(tcap_pkg::OP_DONE_PROG, 6'h00, 56'h0);
        check("done", 56'h0, {55'h0, done});
        run(tcap_pkg::OP_PROG_EN, 6'h00, 56'h0);
        check("mode", 56'h1, {55'h0, prog_mode});
        nrst_host = 1'b0;
        repeat (6) @(negedge clk);
        nrst_host = 1'b1;
        wait_sig(cmd_ready, 1'b1);
        check("mode", 56'h0, {55'h0, prog_mode});
        run(tcap_pkg::OP_BYPASS, 6'h01, 56'h1);
        check("bypass", 56'h0, {55'h0, rsp_data[0]});
        print_verdict();
    end
endmodule : testbench
